// *** hw/lps_pkg.sv ***
// lps_pkg: offsets, field positions, reset values and cycle counts
// assumes a 200 MHz device clock and an 8-bit register port
package lps_pkg;
    // register offsets on the 8-bit register port
    localparam logic [7:0] ADDR_DBG_MIRROR = 8'hC0;
    localparam logic [7:0] ADDR_DBG_CTRL   = 8'hC1;
    localparam logic [7:0] ADDR_STATUS     = 8'hC4;
    localparam logic [7:0] ADDR_KEY_FIFO   = 8'hC9;
    // field positions of the mirror register
    localparam int MIR_I2C_FAST_BIT  = 0;
    localparam int MIR_SPEEDUP_BIT   = 1;
    localparam int MIR_FAST_LINK_VERIFY_BIT   = 2;
    localparam int MIR_CHKSUM_EN_BIT = 3;
    localparam int MIR_TO_DIS_BIT    = 6;
    // field positions of control and status
    localparam int CTRL_POLICY_BIT  = 0;
    localparam int CTRL_NO_DEC_BIT  = 1;
    localparam int STS_AUTH_COMPLETE_FLAG_BIT   = 0;
    localparam int STS_CHK_ERR_BIT  = 1;
    // values after reset
    localparam logic [7:0] MIRROR_RESET   = 8'h00;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] STATUS_RESET   = 8'h00;
    localparam logic [7:0] KEY_FIFO_RESET = 8'h00;
    // clock and times
    localparam longint CLK_PERIOD_NS   = 5;
    localparam longint I2C_TIMEOUT_NS  = 1000000000;
    localparam longint SCL_STD_NS      = 10000;
    localparam longint SCL_FAST_NS     = 2500;
    localparam longint AUTH_TICK_NS    = 1000000;
    // cycle counts, least times rounded up
    localparam int I2C_TIMEOUT_CYC =
        int'((I2C_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int SCL_STD_CYC  = int'((SCL_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int SCL_FAST_CYC = int'((SCL_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int AUTH_TICK_CYC =
        int'((AUTH_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int AUTH_SPEEDUP_SHIFT = 4;
    // verification intervals in frames
    localparam int FC_FRAMES_FAST = 2;
    localparam int FC_FRAMES_SLOW = 16;
    localparam int LI_FRAMES_FAST = 16;
    localparam int LI_FRAMES_SLOW = 128;
    localparam int FRAME_CNT_W    = 7;
endpackage : lps_pkg

// *** hw/lps_line_sum.sv ***
// lps_line_sum: ones-complement sum of one colour channel over a line
// assumes the line checksum arrives after the last pixel of the line
`timescale 1ns/100ps
module lps_line_sum #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    // pixel stream
    input  wire logic         pix_valid,
    input  wire logic [W-1:0] pix_byte,
    // received checksum
    input  wire logic         chk_valid,
    input  wire logic [W-1:0] chk_byte,
    // compare result, one-cycle pulse
    output logic              mismatch_ff
);
    logic [W-1:0] sum_ff;
    logic [W-1:0] nxt_sum;
    logic         nxt_mismatch;
    logic [W:0]   raw;

    // end-around carry add, compare and restart at each checksum
    always_comb begin
        raw          = {1'b0, sum_ff} + {1'b0, pix_byte};
        nxt_sum      = sum_ff;
        nxt_mismatch = 1'b0;
        if (chk_valid) begin
            nxt_mismatch = (~sum_ff != chk_byte);
            nxt_sum      = '0;
        end else if (pix_valid) begin
            nxt_sum = raw[W-1:0] + W'(raw[W]);
        end
    end

    // register the running sum
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sum_ff      <= '0;
            mismatch_ff <= 1'b0;
        end else begin
            sum_ff      <= nxt_sum;
            mismatch_ff <= nxt_mismatch;
        end
    end
endmodule // lps_line_sum

// *** hw/lps_debug_status.sv ***
// lps_debug_status: debug, control and status bank of the protection receiver
// assumes remote settings arrive as levels and events as one-cycle pulses
// Behaviour
// - enabled timeout frees bus after 1 s idle
// - timeout-disable bit suppresses the idle timeout
// - transmitter sends per-channel line checksum after line
// - fast verify: frame check 2, integrity 16
// - slow verify: frame check 16, integrity 128
// - speed-up bit accelerates authentication timers
// - fast bit picks fast or standard timing
// - mirror register read-only, copies remote settings
// - no-decrypt passes encrypted pixels to outputs
// - policy 1: leave enabled downstream protection alone
// - policy 0: re-enable downstream at each start
// - checksum mismatch sets error flag when enabled
// - any write to status clears error
// - successful authentication sets authenticated flag
// - loss or restart clears authenticated flag
`timescale 1ns/100ps
module lps_debug_status #(
    parameter int TIMEOUT_CYC   = lps_pkg::I2C_TIMEOUT_CYC,
    parameter int AUTH_TICK_CYC = lps_pkg::AUTH_TICK_CYC
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata_ff,
    // settings copied from the remote transmitter
    input  wire logic        mir_i2c_timeout_disable,
    input  wire logic        mir_line_checksum_enable,
    input  wire logic        mir_fast_link_verify,
    input  wire logic        mir_auth_timer_speedup,
    input  wire logic        mir_i2c_fast_timing,
    // protection i2c controller
    input  wire logic        i2c_activity,
    output logic             i2c_idle_free_ff,
    output logic             i2c_bit_tick_ff,
    // authentication
    input  wire logic        frame_start,
    input  wire logic        auth_start,
    input  wire logic        auth_ok,
    input  wire logic        auth_lost,
    input  wire logic        downstream_prot_on,
    output logic             frame_check_tick_ff,
    output logic             link_integrity_tick_ff,
    output logic             auth_timer_tick_ff,
    output logic             downstream_enable_ff,
    // pixel path
    input  wire logic        pix_valid,
    input  wire logic [23:0] enc_rgb,
    input  wire logic [23:0] dec_rgb,
    input  wire logic        chk_valid,
    input  wire logic [23:0] chk_rgb,
    output logic [23:0]      rgb_out_ff,
    output logic             rgb_valid_ff,
    // key list data port
    output logic [7:0]       key_fifo_data_ff,
    output logic             key_fifo_wr_ff
);
    // refuse counts the dividers cannot serve
    if (TIMEOUT_CYC < 2 || AUTH_TICK_CYC < (2 << lps_pkg::AUTH_SPEEDUP_SHIFT)) begin : g_chk
        $error("lps_debug_status: count parameters too small");
    end

    // ---- register bank ----
    logic [7:0] mirror_ff, nxt_mirror;
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [7:0] nxt_rdata, nxt_key_data;
    logic       nxt_key_wr;
    logic       auth_complete_flag_ff, nxt_auth_complete_flag;
    logic       chk_err_ff, nxt_chk_err;
    logic       sts_wr;
    logic [2:0] mismatch;
    logic       any_mismatch;

    assign sts_wr       = reg_wr && (reg_addr == lps_pkg::ADDR_STATUS);
    assign any_mismatch = |mismatch && mirror_ff[lps_pkg::MIR_CHKSUM_EN_BIT];

    // mirror copy, control writes, status flags and read data
    always_comb begin
        nxt_mirror = lps_pkg::MIRROR_RESET; // reserved bits read zero
        nxt_mirror[lps_pkg::MIR_I2C_FAST_BIT]  = mir_i2c_fast_timing;
        nxt_mirror[lps_pkg::MIR_SPEEDUP_BIT]   = mir_auth_timer_speedup;
        nxt_mirror[lps_pkg::MIR_FAST_LINK_VERIFY_BIT]   = mir_fast_link_verify;
        nxt_mirror[lps_pkg::MIR_CHKSUM_EN_BIT] = mir_line_checksum_enable;
        nxt_mirror[lps_pkg::MIR_TO_DIS_BIT]    = mir_i2c_timeout_disable;
        nxt_ctrl     = ctrl_ff;
        nxt_key_data = key_fifo_data_ff;
        nxt_key_wr   = 1'b0;
        if (reg_wr && reg_addr == lps_pkg::ADDR_DBG_CTRL) begin
            nxt_ctrl = 8'h00;
            nxt_ctrl[lps_pkg::CTRL_POLICY_BIT] = reg_wdata[lps_pkg::CTRL_POLICY_BIT];
            nxt_ctrl[lps_pkg::CTRL_NO_DEC_BIT] = reg_wdata[lps_pkg::CTRL_NO_DEC_BIT];
        end
        if (reg_wr && reg_addr == lps_pkg::ADDR_KEY_FIFO) begin
            nxt_key_data = reg_wdata;
            nxt_key_wr   = 1'b1;
        end
        // sticky error: a new mismatch wins over the clearing write
        nxt_chk_err = chk_err_ff;
        if (sts_wr) begin
            nxt_chk_err = 1'b0;
        end
        if (any_mismatch) begin
            nxt_chk_err = 1'b1;
        end
        // authenticated: success wins over a same-cycle loss or restart
        nxt_auth_complete_flag = auth_complete_flag_ff;
        if (auth_lost || auth_start) begin
            nxt_auth_complete_flag = 1'b0;
        end
        if (auth_ok) begin
            nxt_auth_complete_flag = 1'b1;
        end
        nxt_rdata = 8'h00; // unmapped reads return zero
        if (reg_rd) begin
            case (reg_addr)
                lps_pkg::ADDR_DBG_MIRROR: nxt_rdata = mirror_ff;
                lps_pkg::ADDR_DBG_CTRL:   nxt_rdata = ctrl_ff;
                lps_pkg::ADDR_STATUS: begin
                    nxt_rdata[lps_pkg::STS_AUTH_COMPLETE_FLAG_BIT]  = auth_complete_flag_ff;
                    nxt_rdata[lps_pkg::STS_CHK_ERR_BIT] = chk_err_ff;
                end
                lps_pkg::ADDR_KEY_FIFO:   nxt_rdata = key_fifo_data_ff;
                default:                  nxt_rdata = 8'h00;
            endcase
        end
    end

    // register bank flops; writes to the mirror offset are ignored
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mirror_ff        <= lps_pkg::MIRROR_RESET;
            ctrl_ff          <= lps_pkg::CTRL_RESET;
            auth_complete_flag_ff        <= lps_pkg::STATUS_RESET[lps_pkg::STS_AUTH_COMPLETE_FLAG_BIT];
            chk_err_ff       <= lps_pkg::STATUS_RESET[lps_pkg::STS_CHK_ERR_BIT];
            key_fifo_data_ff <= lps_pkg::KEY_FIFO_RESET;
            key_fifo_wr_ff   <= 1'b0;
            reg_rdata_ff     <= 8'h00;
        end else begin
            mirror_ff        <= nxt_mirror;
            ctrl_ff          <= nxt_ctrl;
            auth_complete_flag_ff        <= nxt_auth_complete_flag;
            chk_err_ff       <= nxt_chk_err;
            key_fifo_data_ff <= nxt_key_data;
            key_fifo_wr_ff   <= nxt_key_wr;
            reg_rdata_ff     <= nxt_rdata;
        end
    end

    // ---- protection i2c timing ----
    logic [31:0] idle_cnt_ff, nxt_idle_cnt;
    logic [11:0] scl_cnt_ff, nxt_scl_cnt;
    logic [11:0] scl_last;
    logic        nxt_idle_free, nxt_bit_tick;

    // idle timeout and bit-rate divider
    always_comb begin
        nxt_idle_cnt  = idle_cnt_ff;
        nxt_idle_free = i2c_idle_free_ff;
        if (i2c_activity || mirror_ff[lps_pkg::MIR_TO_DIS_BIT]) begin
            nxt_idle_cnt  = 32'h0000_0000;
            nxt_idle_free = 1'b0;
        end else if (idle_cnt_ff >= 32'(TIMEOUT_CYC)) begin
            nxt_idle_free = 1'b1;
        end else begin
            nxt_idle_cnt = idle_cnt_ff + 32'h0000_0001;
        end
        scl_last = mirror_ff[lps_pkg::MIR_I2C_FAST_BIT]
                 ? 12'(lps_pkg::SCL_FAST_CYC - 1)
                 : 12'(lps_pkg::SCL_STD_CYC - 1);
        nxt_bit_tick = 1'b0;
        nxt_scl_cnt  = scl_cnt_ff + 12'h001;
        if (scl_cnt_ff >= scl_last) begin
            nxt_scl_cnt  = 12'h000;
            nxt_bit_tick = 1'b1;
        end
    end

    // i2c timing flops
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            idle_cnt_ff      <= 32'h0000_0000;
            i2c_idle_free_ff <= 1'b0;
            scl_cnt_ff       <= 12'h000;
            i2c_bit_tick_ff  <= 1'b0;
        end else begin
            idle_cnt_ff      <= nxt_idle_cnt;
            i2c_idle_free_ff <= nxt_idle_free;
            scl_cnt_ff       <= nxt_scl_cnt;
            i2c_bit_tick_ff  <= nxt_bit_tick;
        end
    end

    // ---- authentication timing ----
    logic [lps_pkg::FRAME_CNT_W-1:0] frame_cnt_ff, nxt_frame_cnt;
    logic [lps_pkg::FRAME_CNT_W-1:0] fc_mask, li_mask;
    logic [31:0] auth_cnt_ff, nxt_auth_cnt;
    logic [31:0] auth_last;
    logic        nxt_fc_tick, nxt_li_tick, nxt_auth_tick, nxt_ds_en;

    // frame intervals, timer tick and downstream enable policy
    always_comb begin
        if (mirror_ff[lps_pkg::MIR_FAST_LINK_VERIFY_BIT]) begin
            fc_mask = lps_pkg::FRAME_CNT_W'(lps_pkg::FC_FRAMES_FAST - 1);
            li_mask = lps_pkg::FRAME_CNT_W'(lps_pkg::LI_FRAMES_FAST - 1);
        end else begin
            fc_mask = lps_pkg::FRAME_CNT_W'(lps_pkg::FC_FRAMES_SLOW - 1);
            li_mask = lps_pkg::FRAME_CNT_W'(lps_pkg::LI_FRAMES_SLOW - 1);
        end
        nxt_frame_cnt = frame_cnt_ff;
        nxt_fc_tick   = 1'b0;
        nxt_li_tick   = 1'b0;
        if (auth_start) begin
            nxt_frame_cnt = '0;
        end else if (frame_start) begin
            nxt_frame_cnt = frame_cnt_ff + 1'b1;
            nxt_fc_tick   = (frame_cnt_ff & fc_mask) == fc_mask;
            nxt_li_tick   = (frame_cnt_ff & li_mask) == li_mask;
        end
        auth_last = mirror_ff[lps_pkg::MIR_SPEEDUP_BIT]
                  ? 32'(AUTH_TICK_CYC >> lps_pkg::AUTH_SPEEDUP_SHIFT) - 32'h0000_0001
                  : 32'(AUTH_TICK_CYC) - 32'h0000_0001;
        nxt_auth_tick = 1'b0;
        nxt_auth_cnt  = auth_cnt_ff + 32'h0000_0001;
        if (auth_cnt_ff >= auth_last) begin
            nxt_auth_cnt  = 32'h0000_0000;
            nxt_auth_tick = 1'b1;
        end
        // policy 1 skips transmitters that already report protection on
        nxt_ds_en = auth_start &&
                    !(ctrl_ff[lps_pkg::CTRL_POLICY_BIT] && downstream_prot_on);
    end

    // authentication timing flops
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            frame_cnt_ff           <= '0;
            frame_check_tick_ff    <= 1'b0;
            link_integrity_tick_ff <= 1'b0;
            auth_cnt_ff            <= 32'h0000_0000;
            auth_timer_tick_ff     <= 1'b0;
            downstream_enable_ff   <= 1'b0;
        end else begin
            frame_cnt_ff           <= nxt_frame_cnt;
            frame_check_tick_ff    <= nxt_fc_tick;
            link_integrity_tick_ff <= nxt_li_tick;
            auth_cnt_ff            <= nxt_auth_cnt;
            auth_timer_tick_ff     <= nxt_auth_tick;
            downstream_enable_ff   <= nxt_ds_en;
        end
    end

    // ---- pixel path and line checksum ----
    logic [23:0] nxt_rgb;

    // one accumulator per colour channel, fed with encrypted link data
    for (genvar ch = 0; ch < 3; ch++) begin : g_sum
        lps_line_sum #(
            .W (8)
        ) u_sum (
            .mclk        (mclk),
            .sys_rst     (sys_rst),
            .pix_valid   (pix_valid),
            .pix_byte    (enc_rgb[ch*8 +: 8]),
            .chk_valid   (chk_valid),
            .chk_byte    (chk_rgb[ch*8 +: 8]),
            .mismatch_ff (mismatch[ch])
        );
    end

    // output select between decrypted and raw pixels
    always_comb begin
        nxt_rgb = rgb_out_ff;
        if (pix_valid) begin
            nxt_rgb = ctrl_ff[lps_pkg::CTRL_NO_DEC_BIT] ? enc_rgb : dec_rgb;
        end
    end

    // pixel flops
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rgb_out_ff   <= 24'h000000;
            rgb_valid_ff <= 1'b0;
        end else begin
            rgb_out_ff   <= nxt_rgb;
            rgb_valid_ff <= pix_valid;
        end
    end

    // ---- checks ----
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    timeout_free_a: assert property (
        !i2c_activity && !mirror_ff[lps_pkg::MIR_TO_DIS_BIT]
        && idle_cnt_ff >= 32'(TIMEOUT_CYC) |=> i2c_idle_free_ff)
        else $error("idle timeout did not free the bus");
    timeout_dis_a: assert property (
        $rose(i2c_idle_free_ff) |-> !$past(mirror_ff[lps_pkg::MIR_TO_DIS_BIT]))
        else $error("bus freed while timeout disabled");
    fc_period_a: assert property (
        frame_start && !auth_start && mirror_ff[lps_pkg::MIR_FAST_LINK_VERIFY_BIT]
        |=> frame_check_tick_ff == $past(frame_cnt_ff[0]))
        else $error("fast frame check interval wrong");
    li_slow_a: assert property (
        frame_start && !auth_start && !mirror_ff[lps_pkg::MIR_FAST_LINK_VERIFY_BIT]
        |=> link_integrity_tick_ff == ($past(frame_cnt_ff) == 7'h7F))
        else $error("slow integrity interval wrong");
    no_decrypt_a: assert property (
        pix_valid && ctrl_ff[lps_pkg::CTRL_NO_DEC_BIT] |=> rgb_out_ff == $past(enc_rgb))
        else $error("encrypted pixels not passed");
    reenable_req_a: assert property (
        auth_start && !ctrl_ff[lps_pkg::CTRL_POLICY_BIT] |=> downstream_enable_ff)
        else $error("downstream not re-enabled");
    reenable_skip_a: assert property (
        auth_start && ctrl_ff[lps_pkg::CTRL_POLICY_BIT] && downstream_prot_on
        |=> !downstream_enable_ff)
        else $error("downstream re-enabled against policy");
    chk_err_set_a: assert property (
        any_mismatch |=> chk_err_ff ##1 (chk_err_ff || $past(sts_wr)))
        else $error("checksum error flag not set");
    chk_err_clr_a: assert property (
        sts_wr && !any_mismatch |=> !chk_err_ff)
        else $error("status write did not clear error");
    auth_flag_a: assert property (
        (auth_lost || auth_start) && !auth_ok |=> !auth_complete_flag_ff
        ##1 (reg_rdata_ff[lps_pkg::STS_AUTH_COMPLETE_FLAG_BIT] == 1'b0 || !$past(reg_rd)))
        else $error("authenticated flag not cleared");
endmodule // lps_debug_status

// *** test/lps_tx_model.sv ***
// lps_tx_model: remote transmitter model driving settings, frames and lines
// assumes mclk from the bench; its tasks are called by the bench
`timescale 1ns/100ps
module lps_tx_model (
    // clock
    input  wire logic   mclk,
    // settings written into the remote debug register
    output logic        mir_i2c_timeout_disable,
    output logic        mir_line_checksum_enable,
    output logic        mir_fast_link_verify,
    output logic        mir_auth_timer_speedup,
    output logic        mir_i2c_fast_timing,
    // frame and pixel stream
    output logic        frame_start,
    output logic        pix_valid,
    output logic [23:0] enc_rgb,
    output logic [23:0] dec_rgb,
    output logic        chk_valid,
    output logic [23:0] chk_rgb
);
    // idle levels at time zero
    initial begin
        {mir_i2c_timeout_disable, mir_line_checksum_enable} = 2'h0;
        {mir_fast_link_verify, mir_auth_timer_speedup, mir_i2c_fast_timing} = 3'h0;
        {frame_start, pix_valid, chk_valid} = 3'h0;
        {enc_rgb, dec_rgb, chk_rgb} = 72'h0;
    end

    // pixel pattern, large bytes so channel sums carry
    function automatic logic [23:0] pixel(input int i);
        return 24'hF0E0D0 + 24'h0B1713 * i[23:0];
    endfunction

    // remote debug register write, seen here as levels
    task automatic set_mir(input logic [6:0] m);
        @(posedge mclk);
        mir_i2c_timeout_disable  <= m[6];
        mir_line_checksum_enable <= m[3];
        mir_fast_link_verify     <= m[2];
        mir_auth_timer_speedup   <= m[1];
        mir_i2c_fast_timing      <= m[0];
    endtask

    // one frame-start pulse every two cycles
    task automatic frames(input int n);
        repeat (n) begin
            @(posedge mclk);
            frame_start <= n > 0;
            @(posedge mclk);
            frame_start <= 1'b0;
        end
    endtask

    // a line of n pixels, then the per-channel checksum; bad flips one bit
    task automatic send_line(input int n, input bit bad);
        logic [23:0] sum;
        logic [23:0] p;
        logic [8:0]  t;
        sum = 24'h000000;
        for (int i = 0; i < n; i++) begin
            p = pixel(i);
            @(posedge mclk);
            pix_valid <= i < n;
            enc_rgb   <= p;
            dec_rgb   <= ~p;
            for (int c = 0; c < 3; c++) begin
                t = {1'b0, sum[c*8+:8]} + {1'b0, p[c*8+:8]};
                sum[c*8+:8] = t[7:0] + {7'h00, t[8]}; // end-around carry
            end
        end
        @(posedge mclk);
        pix_valid <= 1'b0;
        enc_rgb   <= ~enc_rgb;
        dec_rgb   <= ~dec_rgb;
        chk_valid <= n > 0; // checksum follows every non-empty line
        chk_rgb   <= ~sum ^ (bad ? 24'h000100 : 24'h000000);
        @(posedge mclk);
        chk_valid <= 1'b0;
        chk_rgb   <= ~chk_rgb;
    endtask
endmodule // lps_tx_model

// *** test/testbench.sv ***
// testbench: self-checking bench for the protection debug and status bank
// assumes lps_debug_status and lps_tx_model; short timeout and tick counts
`timescale 1ns/100ps
module testbench;
    // clock, reset and bench-driven inputs
    logic        mclk;
    logic        sys_rst;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic        i2c_activity;
    logic        auth_start;
    logic        auth_ok;
    logic        auth_lost;
    logic        downstream_prot_on;
    int          miscompares;
    int          compares;
    int          fc_n;
    int          li_n;
    int          pv_n;
    // design outputs and partner drives
    wire logic [7:0]  reg_rdata_ff;
    wire logic [7:0]  key_fifo_data_ff;
    wire logic [23:0] rgb_out_ff;
    wire logic [23:0] enc_rgb;
    wire logic [23:0] dec_rgb;
    wire logic [23:0] chk_rgb;
    wire logic mir_i2c_timeout_disable, mir_line_checksum_enable, mir_fast_link_verify;
    wire logic mir_auth_timer_speedup, mir_i2c_fast_timing, frame_start, pix_valid, chk_valid;
    wire logic i2c_idle_free_ff, i2c_bit_tick_ff, frame_check_tick_ff, link_integrity_tick_ff;
    wire logic auth_timer_tick_ff, downstream_enable_ff, rgb_valid_ff, key_fifo_wr_ff;

    // device under test with short counts
    lps_debug_status #(.TIMEOUT_CYC(20), .AUTH_TICK_CYC(64)) DUT (.*);
    // remote transmitter
    lps_tx_model u_tx (.*);

    // clock generator
    always #2.5 mclk = ~mclk;

    // tick counters, sampled away from the rising edge
    always @(negedge mclk) begin
        if (frame_check_tick_ff === 1'b1) fc_n++;
        if (link_integrity_tick_ff === 1'b1) li_n++;
        if (rgb_valid_ff === 1'b1) pv_n++;
    end

    // compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic final_report();
        if (miscompares == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // register write, one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    // register read, data checked in the following cycle only
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        check(name, {24'h0, reg_rdata_ff}, {24'h0, exp});
    endtask

    // one-cycle event: 0 start, 1 success, 2 loss, 3 bus activity
    task automatic pulse(input int s);
        @(posedge mclk);
        auth_start   <= s == 0;
        auth_ok      <= s == 1;
        auth_lost    <= s == 2;
        i2c_activity <= s == 3;
        @(posedge mclk);
        {auth_start, auth_ok, auth_lost, i2c_activity} <= 4'h0;
        #1;
    endtask

    // cycles between the second and third pulse of a tick output
    task automatic period(input int s, input int exp, input string name);
        int n;
        n = 0;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(posedge mclk);
                #1;
                n++;
            end while ((s == 0 ? i2c_bit_tick_ff : auth_timer_tick_ff) !== 1'b1 && n < 5000);
        end
        check(name, n, exp);
    endtask

    // reset values, unmapped read, mirror copy and write protection
    task automatic test_regs();
        rd(8'hC1, 8'h00, "ctrl reset");
        rd(8'hC4, 8'h00, "status reset");
        rd(8'hC2, 8'h00, "unmapped read");
        u_tx.set_mir(7'h4F);
        rd(8'hC0, 8'h4F, "mirror copy");
        wr(8'hC0, 8'h00);
        rd(8'hC0, 8'h4F, "mirror write ignored");
        u_tx.set_mir(7'h00);
        rd(8'hC0, 8'h00, "mirror clear");
        wr(8'hC9, 8'hA5);
        check("key port pulse", key_fifo_wr_ff, 1);
        check("key port byte", key_fifo_data_ff, 8'hA5);
        rd(8'hC9, 8'hA5, "key port data");
    endtask

    // pixel source selection by the no-decrypt bit
    task automatic test_pixels();
        wr(8'hC1, 8'hFE);
        rd(8'hC1, 8'h02, "ctrl writable bits");
        u_tx.send_line(4, 1'b0);
        check("encrypted out", rgb_out_ff, {8'h0, u_tx.pixel(3)});
        wr(8'hC1, 8'h00);
        u_tx.send_line(4, 1'b0);
        check("decrypted out", rgb_out_ff, {8'h0, ~u_tx.pixel(3)});
        check("valid pulses", pv_n, 8);
    endtask

    // good, bad, cleared and disabled checksum lines
    task automatic test_checksum();
        u_tx.set_mir(7'h08);
        u_tx.send_line(5, 1'b0);
        rd(8'hC4, 8'h00, "good line");
        u_tx.send_line(5, 1'b1);
        rd(8'hC4, 8'h02, "bad line");
        u_tx.send_line(5, 1'b0);
        rd(8'hC4, 8'h02, "error sticky");
        wr(8'hC4, 8'h5A);
        rd(8'hC4, 8'h00, "error cleared");
        u_tx.set_mir(7'h00);
        u_tx.send_line(5, 1'b1);
        rd(8'hC4, 8'h00, "checksum disabled");
    endtask

    // authenticated flag set, lost and restarted
    task automatic test_auth();
        pulse(1);
        rd(8'hC4, 8'h01, "auth set");
        pulse(2);
        rd(8'hC4, 8'h00, "auth lost");
        pulse(1);
        pulse(0);
        rd(8'hC4, 8'h00, "auth restart");
    endtask

    // downstream re-enable policy across both states of the attached side
    task automatic test_policy();
        for (int p = 0; p < 2; p++) begin
            for (int d = 0; d < 2; d++) begin
                wr(8'hC1, {7'h00, p[0]});
                @(posedge mclk) downstream_prot_on <= d[0];
                pulse(0);
                check("downstream enable", downstream_enable_ff, !(p && d));
            end
        end
        downstream_prot_on <= 1'b0;
    endtask

    // verification tick counts over 16 fast or 128 slow frames
    task automatic test_frames();
        for (int f = 1; f >= 0; f--) begin
            u_tx.set_mir({4'h0, f[0], 2'h0});
            pulse(0);
            fc_n = 0;
            li_n = 0;
            u_tx.frames(f ? 16 : 128);
            repeat (3) @(posedge mclk);
            check("frame check ticks", fc_n, 8);
            check("integrity ticks", li_n, 1);
        end
    endtask

    // idle timeout, its disable, bus and timer tick rates
    task automatic test_timing();
        int n;
        n = 0;
        u_tx.set_mir(7'h00);
        pulse(3);
        check("free drops", i2c_idle_free_ff, 0);
        while (i2c_idle_free_ff !== 1'b1 && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check("idle timeout", n, 21);
        u_tx.set_mir(7'h40);
        repeat (40) @(posedge mclk);
        #1;
        check("timeout disabled", i2c_idle_free_ff, 0);
        u_tx.set_mir(7'h00);
        period(0, 2000, "standard bit rate");
        u_tx.set_mir(7'h01);
        period(0, 500, "fast bit rate");
        u_tx.set_mir(7'h00);
        period(1, 64, "auth tick");
        u_tx.set_mir(7'h02);
        period(1, 4, "auth tick speedup");
    endtask

    // watchdog against a hang
    initial begin
        #300000;
        miscompares++;
        final_report();
    end

    // main sequence
    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
        {i2c_activity, auth_start, auth_ok, auth_lost, downstream_prot_on} = 5'h0;
        {miscompares, compares, fc_n, li_n, pv_n} = 160'h0;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        test_regs();
        test_pixels();
        test_checksum();
        test_auth();
        test_policy();
        test_frames();
        test_timing();
        final_report();
    end
endmodule // testbench
